// ### tb/fwp_extension_bus_cpu.sv
// Extension-bus master model: issues one access and times the ready
`default_nettype none

module fwp_extension_bus_cpu
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       go,
	input  wire logic       xb_ready,
	output logic            xb_access,
	output logic            busy,
	output logic [5:0]      lat
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [5:0] cnt_r;

	// One-cycle access pulse; a real master never retries while it waits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			xb_access <= 1'b0;
			busy      <= 1'b0;
			cnt_r     <= 6'h00;
			lat       <= 6'h00;
		end
		else if (go && !busy)
		begin
			xb_access <= 1'b1;
			busy      <= 1'b1;
			cnt_r     <= 6'h00;
		end
		else if (busy)
		begin
			xb_access <= 1'b0;
			cnt_r     <= cnt_r + 6'h01;
			if (xb_ready)
			begin
				busy <= 1'b0;
				lat  <= cnt_r;
			end
		end
	end
endmodule

`default_nettype wire

// ### tb/fwp_flash_protect_test.sv
// Self-checking bench: APB registers, wait states and sector protection
`default_nettype none

module fwp_flash_protect_test
	import fwp_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [19:0]   paddr;
	logic [31:0]   pwdata, prdata, rd;
	fwp_fuse_set_t nv_fuse_cells;
	logic          exec_from_bank2, temp_unprotect, xb_access, xb_ready, go, busy;
	logic          pe_valid, pe_done, irq;
	fwp_pe_req_t   pe_req;
	logic [9:0]    pe_allow;
	logic [5:0]    lat;
	int            err_total = 0;
	int            cmp_count = 0;
	int            cycles    = 0;

	// ADR, BMSK and SEC indexed by bank number; WS lists the wait settings tried in turn
	localparam logic [19:0] ADR [4] = '{FWP_ADDR_BANK0, FWP_ADDR_BANK1,
		FWP_ADDR_BANK2, FWP_ADDR_BANK3};
	localparam logic [15:0] BMSK [4] = '{FWP_BANK0_MASK, FWP_BANK1_MASK,
		FWP_BANK2_MASK, FWP_BANK3_MASK};
	localparam logic [9:0]  SEC [4] = '{10'h3ff, 10'h003, 10'h007, 10'h003};
	localparam logic [3:0]  WS [3] = '{4'h1, 4'h0, 4'h5};

	fwp_flash_protect i_fwp_flash_protect (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .nv_fuse_cells, .exec_from_bank2,
		.temp_unprotect, .xb_access, .xb_ready, .pe_valid, .pe_req, .pe_allow, .pe_done,
		.irq);

	fwp_extension_bus_cpu i_fwp_extension_bus_cpu (.pclk, .presetn, .go, .xb_ready, .xb_access, .busy, .lat);

	// ****************************************************************
	// Clock, timeout and closing
	// ****************************************************************
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Whole run is well under a thousand cycles
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_total++;
			$display("Error at %0t: run hung", $time);
			wrap_up();
		end
	end

	// ****************************************************************
	// Access tasks
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask

	// An idle cycle follows each transfer so no strobe is driven twice in one step
	task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait for ready
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic xb_run(input logic [3:0] w);
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		do
		begin
			@(posedge pclk);
		end
		while (busy !== 1'b0);
		check(32'(lat), 32'(w) + 32'h1, "wait states");
	endtask

	task automatic pe_run(input int b, input logic [9:0] exp);
		pe_valid <= 1'b1;
		pe_req   <= '{bank: fwp_bank_t'(b), sectors: 10'h3ff};
		@(posedge pclk);
		pe_valid <= 1'b0;
		@(posedge pclk);
		check({31'h0, pe_done}, 32'h1, "pe done");
		check({22'h0, pe_allow}, {22'h0, exp}, "pe allow");
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 20'h00000;
		pwdata = 32'h0;
		nv_fuse_cells = '1;
		exec_from_bank2 = 1'b0;
		temp_unprotect = 1'b0;
		pe_valid = 1'b0;
		pe_req = '0;
		go = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// A request at the copy edge must find every sector locked
		pe_run(0, 10'h000);
		nv_fuse_cells <= '0;
		apb(1'b0, FWP_ADDR_STATUS, 32'h0);
		check(rd, 32'h1, "early request flag");
		apb(1'b1, FWP_ADDR_STATUS, 32'h1);
		apb(1'b0, FWP_ADDR_WAIT, 32'h0);
		check(rd, 32'hf, "wait reset");
		xb_run(4'hf);
		foreach (WS[i])
		begin
			apb(1'b1, FWP_ADDR_WAIT, 32'hfff0 | 32'(WS[i]));
			apb(1'b0, FWP_ADDR_WAIT, 32'h0);
			check(rd, 32'(WS[i]), "wait field");
			xb_run(WS[i]);
		end
		$display("wait state test done");
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, ADR[i], 32'h0);
			check(rd, {16'h0, BMSK[i]}, "fuse copy");
			pe_run(i, SEC[i]);
			apb(1'b0, FWP_ADDR_STATUS, 32'h0);
			check(rd, 32'h0, "no violation");
			apb(1'b1, ADR[i], 32'hfffffffe);
			apb(1'b1, ADR[i], 32'hffffffff);
			apb(1'b0, ADR[i], 32'h0);
			check(rd, {16'h0, BMSK[i] & 16'hfffe}, "one-way fuse");
			pe_run(i, SEC[i] & 10'h3fe);
			apb(1'b0, FWP_ADDR_STATUS, 32'h0);
			check(rd, 32'h1, "violation flag");
			check({31'h0, irq}, 32'h0, "masked irq");
			apb(1'b1, FWP_ADDR_MASK, 32'h1);
			@(posedge pclk);
			check({31'h0, irq}, 32'h1, "irq raised");
			apb(1'b1, FWP_ADDR_STATUS, 32'h1);
			@(posedge pclk);
			check({31'h0, irq}, 32'h0, "irq cleared");
			apb(1'b1, FWP_ADDR_MASK, 32'h0);
		end
		$display("sector protect test done");
		apb(1'b1, FWP_ADDR_BANK2, 32'hffff7fff);
		apb(1'b0, FWP_ADDR_BANK2, 32'h0);
		check(rd, 32'h6, "fuse lock set");
		apb(1'b1, FWP_ADDR_BANK1, 32'h0);
		apb(1'b0, FWP_ADDR_BANK1, 32'h0);
		check(rd, 32'h2, "locked fuse write");
		apb(1'b0, FWP_ADDR_STATUS, 32'h0);
		check(rd, 32'h2, "refused flag");
		exec_from_bank2 <= 1'b1;
		temp_unprotect  <= 1'b1;
		apb(1'b1, FWP_ADDR_BANK1, 32'h0);
		apb(1'b0, FWP_ADDR_BANK1, 32'h0);
		check(rd, 32'h2, "set from bank two");
		exec_from_bank2 <= 1'b0;
		apb(1'b1, FWP_ADDR_BANK1, 32'h0);
		apb(1'b0, FWP_ADDR_BANK1, 32'h0);
		check(rd, 32'h0, "temporary unprotect");
		pe_run(1, 10'h000);
		apb(1'b0, 20'h0edfd0, 32'h0);
		check({31'h0, er}, 32'h1, "unmapped error");
		check(rd, 32'h0, "unmapped data");
		$display("fuse lock test done");
		wrap_up();
	end
endmodule

`default_nettype wire

// ### verilog/fwp_flash_protect.sv
// Flash wait-state generator and sector write protection with an APB register slave
//
// Register access over APB was chosen for this implementation.
`default_nettype none

module fwp_flash_protect
	import fwp_pkg::*;
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [19:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire fwp_fuse_set_t nv_fuse_cells,
	input  wire logic          exec_from_bank2,
	input  wire logic          temp_unprotect,
	input  wire logic          xb_access,
	output logic               xb_ready,
	input  wire logic          pe_valid,
	input  wire fwp_pe_req_t   pe_req,
	output logic      [9:0]    pe_allow,
	output logic               pe_done,
	output logic               irq
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic          [3:0]                wait_count_field_r;
	fwp_fuse_set_t                      fuse_r;
	fwp_fuse_set_t                      fuse_nxt;
	logic                               loaded_r;
	logic          [FWP_NUM_EVENTS-1:0] status_r;
	logic          [FWP_NUM_EVENTS-1:0] mask_r;
	logic          [FWP_NUM_EVENTS-1:0] event_set;
	logic          [31:0]               rdata_nxt;
	logic                               addr_hit;
	logic                               wr_fire;
	logic                               fuse_hit;
	logic                               fuse_write_ok;
	logic          [9:0]                unlocked;
	logic          [9:0]                blocked;
	fwp_xb_state_t                      xb_state_r;
	logic          [3:0]                xb_cnt_r;
	logic          [19:0]               addr_q_r;

	// ****************************************************************
	// APB slave: no wait cycle, ready raised from the setup phase
	// ****************************************************************
	always_comb
	begin
		addr_hit  = 1'b1;
		rdata_nxt = 32'h0000_0000;
		if (paddr == FWP_ADDR_BANK2)
		begin
			rdata_nxt[15:0] = fuse_r.bank2 & FWP_BANK2_MASK;
		end
		else if (paddr == FWP_ADDR_BANK3)
		begin
			rdata_nxt[15:0] = fuse_r.bank3 & FWP_BANK3_MASK;
		end
		else if (paddr == FWP_ADDR_BANK0)
		begin
			rdata_nxt[15:0] = fuse_r.bank0 & FWP_BANK0_MASK;
		end
		else if (paddr == FWP_ADDR_BANK1)
		begin
			rdata_nxt[15:0] = fuse_r.bank1 & FWP_BANK1_MASK;
		end
		else if (paddr == FWP_ADDR_WAIT)
		begin
			rdata_nxt[3:0] = wait_count_field_r;
		end
		else if (paddr == FWP_ADDR_STATUS)
		begin
			rdata_nxt[FWP_NUM_EVENTS-1:0] = status_r;
		end
		else if (paddr == FWP_ADDR_MASK)
		begin
			rdata_nxt[FWP_NUM_EVENTS-1:0] = mask_r;
		end
		else
		begin
			addr_hit = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= 32'h0000_0000;
			addr_q_r <= 20'h00000;
		end
		else
		begin
			pready   <= psel & ~penable;
			pslverr  <= psel & ~penable & ~addr_hit;
			addr_q_r <= paddr;
			if (psel && !penable && !pwrite)
			begin
				prdata <= rdata_nxt;
			end
		end
	end

	// Writes take effect only at the edge where the master sees ready
	assign wr_fire  = psel & penable & pready & pwrite & ~pslverr;
	assign fuse_hit = wr_fire & ((paddr == FWP_ADDR_BANK2) | (paddr == FWP_ADDR_BANK3) |
		(paddr == FWP_ADDR_BANK0) | (paddr == FWP_ADDR_BANK1));

	// ****************************************************************
	// Wait control register
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_count_field_r <= FWP_WAIT_RESET;
		end
		else if (wr_fire && paddr == FWP_ADDR_WAIT)
		begin
			wait_count_field_r <= pwdata[3:0];
		end
	end

	// ****************************************************************
	// Extension bus wait-state generator
	// ****************************************************************
	// The count is sampled at the start of the access, so a rewrite of
	// the wait field never stretches or cuts an access in flight.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			xb_state_r <= FWP_XB_IDLE;
			xb_cnt_r   <= 4'h0;
			xb_ready   <= 1'b0;
		end
		else
		begin
			xb_ready <= 1'b0;
			case (xb_state_r)
				FWP_XB_IDLE:
				begin
					if (xb_access)
					begin
						if (wait_count_field_r == 4'h0)
						begin
							xb_ready <= 1'b1;
						end
						else
						begin
							xb_cnt_r   <= wait_count_field_r - 4'h1;
							xb_state_r <= FWP_XB_WAIT;
						end
					end
				end
				FWP_XB_WAIT:
				begin
					if (xb_cnt_r == 4'h0)
					begin
						xb_ready   <= 1'b1;
						xb_state_r <= FWP_XB_IDLE;
					end
					else
					begin
						xb_cnt_r <= xb_cnt_r - 4'h1;
					end
				end
				default:
				begin
					xb_state_r <= FWP_XB_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Protection registers: fuse copy and set-protection
	// ****************************************************************
	// A fuse write is the set-protection operation; it is refused from
	// bank two and, unless temp_unprotect is high, while the cell write lock is programmed.
	assign fuse_write_ok = ~exec_from_bank2 &
		(fuse_r.bank2[FWP_FUSE_LOCK_BIT] | temp_unprotect);

	always_comb
	begin
		fuse_nxt = fuse_r;
		if (paddr == FWP_ADDR_BANK2)
			fuse_nxt.bank2 = fuse_r.bank2 & (pwdata[15:0] | ~FWP_BANK2_MASK);
		else if (paddr == FWP_ADDR_BANK3)
			fuse_nxt.bank3 = fuse_r.bank3 & (pwdata[15:0] | ~FWP_BANK3_MASK);
		else if (paddr == FWP_ADDR_BANK0)
			fuse_nxt.bank0 = fuse_r.bank0 & (pwdata[15:0] | ~FWP_BANK0_MASK);
		else if (paddr == FWP_ADDR_BANK1)
			fuse_nxt.bank1 = fuse_r.bank1 & (pwdata[15:0] | ~FWP_BANK1_MASK);
	end

	// Reset leaves every lock at zero; the cells are copied at the first
	// edge after release and never sampled again.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fuse_r   <= '{FWP_FUSE_RESET, FWP_FUSE_RESET, FWP_FUSE_RESET, FWP_FUSE_RESET};
			loaded_r <= 1'b0;
		end
		else if (!loaded_r)
		begin
			fuse_r.bank2 <= nv_fuse_cells.bank2 & FWP_BANK2_MASK;
			fuse_r.bank3 <= nv_fuse_cells.bank3 & FWP_BANK3_MASK;
			fuse_r.bank0 <= nv_fuse_cells.bank0 & FWP_BANK0_MASK;
			fuse_r.bank1 <= nv_fuse_cells.bank1 & FWP_BANK1_MASK;
			loaded_r     <= 1'b1;
		end
		else if (fuse_hit && fuse_write_ok)
		begin
			fuse_r <= fuse_nxt;
		end
	end

	// ****************************************************************
	// Program / erase gate
	// ****************************************************************
	always_comb
	begin
		unlocked = 10'h000;
		if (loaded_r)
		begin
			case (pe_req.bank)
				FWP_BANK_0: unlocked = fuse_r.bank0[9:0];
				FWP_BANK_1: unlocked = {8'h00, fuse_r.bank1[1:0]};
				FWP_BANK_2: unlocked = {7'h00, fuse_r.bank2[2:0]};
				FWP_BANK_3: unlocked = {8'h00, fuse_r.bank3[1:0]};
				default:    unlocked = 10'h000;
			endcase
		end
	end

	// Sectors beyond a bank's size do not exist: never allowed, never flagged
	assign blocked = pe_req.sectors & ~unlocked & (pe_req.bank == FWP_BANK_0 ? 10'h3ff :
		pe_req.bank == FWP_BANK_2 ? 10'h007 : 10'h003);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pe_allow <= 10'h000;
			pe_done  <= 1'b0;
		end
		else
		begin
			pe_done <= pe_valid;
			if (pe_valid)
			begin
				pe_allow <= pe_req.sectors & unlocked;
			end
		end
	end

	// ****************************************************************
	// Event status, mask and interrupt
	// ****************************************************************
	assign event_set[FWP_EV_VIOLATION]   = pe_valid & (|blocked);
	assign event_set[FWP_EV_SETPROT_REJ] = fuse_hit & loaded_r & ~fuse_write_ok;

	// Set wins over a write-one-to-clear in the same cycle
	genvar gi;
	generate
		for (gi = 0; gi < FWP_NUM_EVENTS; gi++)
		begin : g_status
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					status_r[gi] <= 1'b0;
				end
				else if (event_set[gi])
				begin
					status_r[gi] <= 1'b1;
				end
				else if (wr_fire && paddr == FWP_ADDR_STATUS && pwdata[gi])
				begin
					status_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask_r <= '0;
			irq    <= 1'b0;
		end
		else
		begin
			if (wr_fire && paddr == FWP_ADDR_MASK)
			begin
				mask_r <= pwdata[FWP_NUM_EVENTS-1:0];
			end
			irq <= |(status_r & mask_r);
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	wait_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(xb_access && xb_state_r == FWP_XB_IDLE && wait_count_field_r == 4'h0) |=> xb_ready)
		else $error("zero-wait access did not get ready next cycle");
	wait_one_a: assert property (@(posedge pclk) disable iff (!presetn)
		(xb_access && xb_state_r == FWP_XB_IDLE && wait_count_field_r == 4'h1)
		|=> !xb_ready ##1 xb_ready)
		else $error("one-wait access ready at wrong cycle");
	wait_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		!loaded_r |-> wait_count_field_r == 4'hf)
		else $error("wait field not fifteen after reset");
	load_once_a: assert property (@(posedge pclk) disable iff (!presetn)
		(loaded_r && !fuse_hit) |=> $stable(fuse_r))
		else $error("protection registers changed without a fuse write");
	all_locked_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!loaded_r && pe_valid) |=> (pe_allow == 10'h000))
		else $error("sector allowed before fuse copy");
	bank2_exec_a: assert property (@(posedge pclk) disable iff (!presetn)
		(loaded_r && fuse_hit && exec_from_bank2) |=> $stable(fuse_r) && status_r[1])
		else $error("set-protection accepted from bank two");
	otp_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(loaded_r) |-> ((fuse_r & ~$past(fuse_r)) == '0))
		else $error("programmed fuse bit returned to one");
	cell_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		(loaded_r && fuse_hit && !fuse_r.bank2[15] && !temp_unprotect) |=> $stable(fuse_r))
		else $error("fuse write passed cell write lock");
	sector_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		pe_valid |=> ((pe_allow & ~$past(unlocked)) == 10'h000) && pe_done)
		else $error("locked sector allowed");
	flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pe_valid && |blocked) |=> status_r[0] ##1 (irq == mask_r[0]))
		else $error("violation flag or interrupt missing");
	reserved_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && addr_q_r == FWP_ADDR_WAIT) |-> (prdata[31:4] == 28'h0000000))
		else $error("reserved wait bits read non-zero");

endmodule

`default_nettype wire

// ### verilog/fwp_pkg.sv
// Package: register map, field layout, reset values and carriers for the flash wait/protect block
`default_nettype none

package fwp_pkg;

	// ****************************************************************
	// Register map (byte addresses on the APB)
	// ****************************************************************
	localparam logic [19:0] FWP_ADDR_BANK2     = 20'h0edfb0;
	localparam logic [19:0] FWP_ADDR_BANK3     = 20'h0edfb4;
	localparam logic [19:0] FWP_ADDR_BANK0     = 20'h0edfb8;
	localparam logic [19:0] FWP_ADDR_BANK1     = 20'h0edfbc;
	localparam logic [19:0] FWP_ADDR_WAIT      = 20'h0edfc0;
	localparam logic [19:0] FWP_ADDR_STATUS    = 20'h0edfc4;
	localparam logic [19:0] FWP_ADDR_MASK      = 20'h0edfc8;

	// ****************************************************************
	// Field layout
	// ****************************************************************
	localparam int          FWP_FUSE_LOCK_BIT  = 15;
	localparam logic [15:0] FWP_BANK2_MASK     = 16'h8007;
	localparam logic [15:0] FWP_BANK3_MASK     = 16'h0003;
	localparam logic [15:0] FWP_BANK0_MASK     = 16'h03ff;
	localparam logic [15:0] FWP_BANK1_MASK     = 16'h0003;
	localparam logic [3:0]  FWP_WAIT_RESET     = 4'hf;
	localparam int          FWP_NUM_EVENTS     = 2;
	localparam int          FWP_EV_VIOLATION   = 0;
	localparam int          FWP_EV_SETPROT_REJ = 1;

	// ****************************************************************
	// Reset values: every sector lock reads as active until fuses load
	// ****************************************************************
	localparam logic [15:0] FWP_FUSE_RESET     = 16'h0000;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef enum logic [1:0] {
		FWP_BANK_0,
		FWP_BANK_1,
		FWP_BANK_2,
		FWP_BANK_3
	} fwp_bank_t;

	typedef struct packed {
		fwp_bank_t   bank;
		logic [9:0]  sectors;
	} fwp_pe_req_t;

	typedef struct packed {
		logic [15:0] bank2;
		logic [15:0] bank3;
		logic [15:0] bank0;
		logic [15:0] bank1;
	} fwp_fuse_set_t;

	typedef enum logic {
		FWP_XB_IDLE,
		FWP_XB_WAIT
	} fwp_xb_state_t;

endpackage

`default_nettype wire
